// file: rtl/adc_serial_config_port.v
// serial configuration port and register bank of the converter
`timescale 1ns/1ps
`include "adc_cfg_consts.vh"
module adc_serial_config_port (
  // clock and reset
  input wire clk,
  input wire nrst,
  // serial link pins
  input wire serial_select_n,
  input wire shift_clk,
  input wire serial_in_line,
  input wire reset_pin,
  // over-range from the datapath and the shared pin
  input wire overrange_flag,
  output reg overrange_or_readback_out,
  // readback state
  output reg readout_active,
  // gain and test pattern
  output reg [3:0] gain_code,
  output reg gain_bypass,
  output reg [2:0] test_pattern_sel,
  output reg [11:0] user_pattern,
  // output driver settings
  output reg [5:0] swing_level,
  output reg swing_override,
  output reg clock_driver_termination,
  output reg data_driver_termination,
  output reg [7:0] interface_clock_edge_ctrl,
  output reg [1:0] clock_fall_position,
  // mode settings
  output reg latency_extend,
  output reg [1:0] data_format,
  output reg offset_corr_en,
  output reg offset_freeze,
  output reg [3:0] offset_time_const,
  output reg [3:0] offset_pedestal,
  output reg [1:0] performance_tune_a_field,
  output reg performance_tune_b_field,
  output reg standby,
  output reg global_power_down,
  output reg output_buffer_power_down,
  output reg low_speed_mode
);

  // ****************************************
  // address decode helpers
  // ****************************************
  function [3:0] slot_of;
    input [7:0] addr;
    begin
      case (addr)
        `ADDR_CTRL: slot_of = `SLOT_CTRL;
        `ADDR_SWING: slot_of = `SLOT_SWING;
        `ADDR_PERF_A: slot_of = `SLOT_PERF_A;
        `ADDR_GAIN: slot_of = `SLOT_GAIN;
        `ADDR_DRV: slot_of = `SLOT_DRV;
        `ADDR_FMT: slot_of = `SLOT_FMT;
        `ADDR_PAT_HI: slot_of = `SLOT_PAT_HI;
        `ADDR_PAT_LO: slot_of = `SLOT_PAT_LO;
        `ADDR_IFC: slot_of = `SLOT_IFC;
        `ADDR_LAT: slot_of = `SLOT_LAT;
        `ADDR_PWR: slot_of = `SLOT_PWR;
        `ADDR_PERF_B: slot_of = `SLOT_PERF_B;
        `ADDR_PED: slot_of = `SLOT_PED;
        `ADDR_OFS: slot_of = `SLOT_OFS;
        `ADDR_SLOW: slot_of = `SLOT_SLOW;
        default: slot_of = `SLOT_NONE;
      endcase
    end
  endfunction

  // reserved bits never store, so they read back as zero
  function [7:0] mask_of;
    input [3:0] slot;
    begin
      case (slot)
        `SLOT_CTRL: mask_of = `MASK_CTRL;
        `SLOT_SWING: mask_of = `MASK_SWING;
        `SLOT_PERF_A: mask_of = `MASK_PERF_A;
        `SLOT_GAIN: mask_of = `MASK_GAIN;
        `SLOT_DRV: mask_of = `MASK_DRV;
        `SLOT_FMT: mask_of = `MASK_FMT;
        `SLOT_PAT_HI: mask_of = `MASK_PAT_HI;
        `SLOT_PAT_LO: mask_of = `MASK_PAT_LO;
        `SLOT_IFC: mask_of = `MASK_IFC;
        `SLOT_LAT: mask_of = `MASK_LAT;
        `SLOT_PWR: mask_of = `MASK_PWR;
        `SLOT_PERF_B: mask_of = `MASK_PERF_B;
        `SLOT_PED: mask_of = `MASK_PED;
        `SLOT_OFS: mask_of = `MASK_OFS;
        `SLOT_SLOW: mask_of = `MASK_SLOW;
        default: mask_of = 8'h00;
      endcase
    end
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  wire [3:0] sync_bus;
  wire rst_pin_s;
  wire select_n_s;
  wire shift_clk_s;
  wire data_s;

  pin_sync #(
    .WIDTH(4),
    .RST_VAL(`SYNC_RESET)
  ) u_pin_sync (
    .clk(clk),
    .nrst(nrst),
    .din({reset_pin, serial_select_n, shift_clk, serial_in_line}),
    .dout(sync_bus)
  );

  assign rst_pin_s = sync_bus[3];
  assign select_n_s = sync_bus[2];
  assign shift_clk_s = sync_bus[1];
  assign data_s = sync_bus[0];

  // ****************************************
  // shift clock edge detection
  // ****************************************
  // only the falling transition counts, so duty cycle does not matter while each phase outlasts one clk period
  reg shift_clk_prev_reg;
  wire shift_fall;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_clk_prev_reg <= 1'b0;
    end else begin
      shift_clk_prev_reg <= shift_clk_s;
    end
  end

  assign shift_fall = shift_clk_prev_reg & ~shift_clk_s & ~select_n_s;

  // ****************************************
  // word assembly
  // ****************************************
  reg [3:0] bit_cnt_reg;
  reg [14:0] shift_in_reg;
  reg [7:0] bank [0:`NUM_SLOTS-1];
  wire [15:0] word;
  wire [7:0] addr_now;
  wire commit;
  wire [3:0] wslot;
  wire [3:0] rslot;
  wire readout;
  wire soft_rst;
  wire write_ok;

  assign word = {shift_in_reg, data_s};
  assign addr_now = {shift_in_reg[6:0], data_s};
  assign commit = shift_fall && (bit_cnt_reg == `WORD_LAST_BIT);
  assign wslot = slot_of(word[15:8]);
  assign rslot = slot_of(addr_now);
  assign readout = bank[`SLOT_CTRL][`CTRL_READOUT_BIT];
  assign soft_rst = commit && (wslot == `SLOT_CTRL) && word[`CTRL_SWRST_BIT];
  assign write_ok = commit && (wslot != `SLOT_NONE) && (!readout || wslot == `SLOT_CTRL);

  // the counter wraps after sixteen, so each word of a burst stands alone
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_reg <= 4'h0;
    end else if (rst_pin_s || select_n_s) begin
      bit_cnt_reg <= 4'h0;
    end else if (shift_fall) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // clearing on select high keeps a cut word from leaking into the next frame
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_in_reg <= 15'h0000;
    end else if (rst_pin_s || select_n_s) begin
      shift_in_reg <= 15'h0000;
    end else if (shift_fall) begin
      shift_in_reg <= word[14:0];
    end
  end

  // ****************************************
  // register bank
  // ****************************************
  integer i;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < `NUM_SLOTS; i = i + 1) begin
        bank[i] <= `REG_DEFAULT;
      end
    end else if (rst_pin_s || soft_rst) begin
      // the reset bit itself is never stored, so it reads back cleared
      for (i = 0; i < `NUM_SLOTS; i = i + 1) begin
        bank[i] <= `REG_DEFAULT;
      end
    end else if (write_ok) begin
      bank[wslot] <= word[7:0] & mask_of(wslot);
    end
  end

  // ****************************************
  // readback shifter
  // ****************************************
  // loaded after the eighth address bit; falls nine to sixteen see d7..d0
  reg [7:0] rd_shift_reg;
  wire [7:0] rd_value;

  assign rd_value = (rslot == `SLOT_NONE || rslot == `SLOT_CTRL) ? 8'h00 : bank[rslot];

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_shift_reg <= 8'h00;
    end else if (rst_pin_s || select_n_s || !readout) begin
      rd_shift_reg <= 8'h00;
    end else if (shift_fall && bit_cnt_reg == `ADDR_LAST_BIT) begin
      rd_shift_reg <= rd_value;
    end else if (shift_fall) begin
      rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
    end
  end

  // ****************************************
  // shared pin
  // ****************************************
  // the pin leaves a register, so it never glitches while its source switches
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overrange_or_readback_out <= 1'b0;
    end else if (readout) begin
      overrange_or_readback_out <= rd_shift_reg[7];
    end else begin
      overrange_or_readback_out <= overrange_flag;
    end
  end

  // tells the system which source currently drives the shared pin
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readout_active <= 1'b0;
    end else begin
      readout_active <= readout;
    end
  end

  // ****************************************
  // decoded settings
  // ****************************************
  // codes above twelve are undefined; they saturate rather than wrap
  wire lat_ext;
  wire gain_off;
  wire [3:0] gain_raw;
  wire [2:0] pat_raw;
  wire swing_on;

  assign lat_ext = bank[`SLOT_LAT][`LAT_EXT_BIT];
  assign gain_off = bank[`SLOT_GAIN][`GAIN_DIS_BIT] | ~lat_ext;
  assign gain_raw = bank[`SLOT_GAIN][`GAIN_HI:`GAIN_LO];
  assign pat_raw = bank[`SLOT_GAIN][`PAT_HI:`PAT_LO];
  assign swing_on = bank[`SLOT_PWR][`SWEN_HI:`SWEN_LO] == `SWEN_ON;

  // gain and pattern stay off in low-latency mode, whatever the bank holds
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gain_code <= 4'h0;
      gain_bypass <= 1'b1;
      test_pattern_sel <= `PAT_NORMAL;
      user_pattern <= 12'h000;
    end else begin
      if (gain_off) begin
        gain_code <= 4'h0;
      end else if (gain_raw > `GAIN_MAX) begin
        gain_code <= `GAIN_MAX;
      end else begin
        gain_code <= gain_raw;
      end
      gain_bypass <= gain_off;
      if (!lat_ext || pat_raw > `PAT_CUSTOM) begin
        test_pattern_sel <= `PAT_NORMAL;
      end else begin
        test_pattern_sel <= pat_raw;
      end
      user_pattern <= {bank[`SLOT_PAT_HI], bank[`SLOT_PAT_LO][`NIB_HI:`NIB_LO]};
    end
  end

  // ****************************************
  // output driver settings
  // ****************************************
  // swing falls back to the default level unless both override bits are set
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      swing_level <= `SWING_DEFAULT;
      swing_override <= 1'b0;
      clock_driver_termination <= 1'b0;
      data_driver_termination <= 1'b0;
      interface_clock_edge_ctrl <= 8'h00;
      clock_fall_position <= 2'h0;
    end else begin
      swing_level <= swing_on ? bank[`SLOT_SWING][`SWING_HI:`SWING_LO] : `SWING_DEFAULT;
      swing_override <= swing_on;
      clock_driver_termination <= bank[`SLOT_DRV][`DRV_CLK_BIT];
      data_driver_termination <= bank[`SLOT_DRV][`DRV_DATA_BIT];
      interface_clock_edge_ctrl <= bank[`SLOT_IFC];
      clock_fall_position <= bank[`SLOT_LAT][`LAT_FALL_HI:`LAT_FALL_LO];
    end
  end

  // ****************************************
  // mode settings
  // ****************************************
  // copies of the bank, except offset_corr_en (gated by lat_ext) and low_speed_mode (both SLOW bits set); the datapath that uses them lies outside this block
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latency_extend <= 1'b0;
      data_format <= 2'h0;
      offset_corr_en <= 1'b0;
      offset_freeze <= 1'b0;
      offset_time_const <= 4'h0;
      offset_pedestal <= 4'h0;
      performance_tune_a_field <= 2'h0;
      performance_tune_b_field <= 1'b0;
      standby <= 1'b0;
      global_power_down <= 1'b0;
      output_buffer_power_down <= 1'b0;
      low_speed_mode <= 1'b0;
    end else begin
      latency_extend <= lat_ext;
      data_format <= bank[`SLOT_FMT][`FMT_HI:`FMT_LO];
      offset_corr_en <= bank[`SLOT_FMT][`OFS_EN_BIT] & lat_ext;
      offset_freeze <= bank[`SLOT_OFS][`OFS_FREEZE_BIT];
      offset_time_const <= bank[`SLOT_OFS][`OFS_TC_HI:`OFS_TC_LO];
      offset_pedestal <= bank[`SLOT_PED][`NIB_HI:`NIB_LO];
      performance_tune_a_field <= bank[`SLOT_PERF_A][`PERF_A_HI:`PERF_A_LO];
      performance_tune_b_field <= bank[`SLOT_PERF_B][`PERF_B_BIT];
      standby <= bank[`SLOT_LAT][`LAT_STBY_BIT];
      global_power_down <= bank[`SLOT_PWR][`PWR_GLOBAL_BIT];
      output_buffer_power_down <= bank[`SLOT_PWR][`PWR_OBUF_BIT];
      low_speed_mode <= bank[`SLOT_SLOW][`SLOW_HI:`SLOW_LO] == `SLOW_ON;
    end
  end

endmodule // adc_serial_config_port

// file: rtl/adc_cfg_consts.vh
// constants of the serial configuration port and its register bank
`ifndef ADC_CFG_CONSTS_VH
`define ADC_CFG_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define ADDR_CTRL 8'h00
`define ADDR_SWING 8'h01
`define ADDR_PERF_A 8'h03
`define ADDR_GAIN 8'h25
`define ADDR_DRV 8'h26
`define ADDR_FMT 8'h3d
`define ADDR_PAT_HI 8'h3f
`define ADDR_PAT_LO 8'h40
`define ADDR_IFC 8'h41
`define ADDR_LAT 8'h42
`define ADDR_PWR 8'h43
`define ADDR_PERF_B 8'h4a
`define ADDR_PED 8'hbf
`define ADDR_OFS 8'hcf
`define ADDR_SLOW 8'hdf

// ****************************************
// storage slots and writable bit masks
// ****************************************
`define NUM_SLOTS 15
`define SLOT_CTRL 4'h0
`define SLOT_SWING 4'h1
`define SLOT_PERF_A 4'h2
`define SLOT_GAIN 4'h3
`define SLOT_DRV 4'h4
`define SLOT_FMT 4'h5
`define SLOT_PAT_HI 4'h6
`define SLOT_PAT_LO 4'h7
`define SLOT_IFC 4'h8
`define SLOT_LAT 4'h9
`define SLOT_PWR 4'ha
`define SLOT_PERF_B 4'hb
`define SLOT_PED 4'hc
`define SLOT_OFS 4'hd
`define SLOT_SLOW 4'he
`define SLOT_NONE 4'hf
`define MASK_CTRL 8'h01
`define MASK_SWING 8'hfc
`define MASK_PERF_A 8'h03
`define MASK_GAIN 8'hff
`define MASK_DRV 8'h03
`define MASK_FMT 8'he0
`define MASK_PAT_HI 8'hff
`define MASK_PAT_LO 8'hf0
`define MASK_IFC 8'hff
`define MASK_LAT 8'hcc
`define MASK_PWR 8'h53
`define MASK_PERF_B 8'h01
`define MASK_PED 8'hf0
`define MASK_OFS 8'hbc
`define MASK_SLOW 8'h30
`define REG_DEFAULT 8'h00

// ****************************************
// field positions and codes
// ****************************************
`define CTRL_SWRST_BIT 1
`define CTRL_READOUT_BIT 0
`define GAIN_HI 7
`define GAIN_LO 4
`define GAIN_DIS_BIT 3
`define PAT_HI 2
`define PAT_LO 0
`define GAIN_MAX 4'hc
`define PAT_NORMAL 3'h0
`define PAT_CUSTOM 3'h5
`define DRV_CLK_BIT 1
`define DRV_DATA_BIT 0
`define SWING_HI 7
`define SWING_LO 2
`define SWING_DEFAULT 6'h00
`define SWEN_HI 1
`define SWEN_LO 0
`define SWEN_ON 2'h3
`define FMT_HI 7
`define FMT_LO 6
`define OFS_EN_BIT 5
`define NIB_HI 7
`define NIB_LO 4
`define LAT_FALL_HI 7
`define LAT_FALL_LO 6
`define LAT_EXT_BIT 3
`define LAT_STBY_BIT 2
`define PWR_GLOBAL_BIT 6
`define PWR_OBUF_BIT 4
`define PERF_A_HI 1
`define PERF_A_LO 0
`define PERF_B_BIT 0
`define OFS_FREEZE_BIT 7
`define OFS_TC_HI 5
`define OFS_TC_LO 2
`define SLOW_HI 5
`define SLOW_LO 4
`define SLOW_ON 2'h3

// ****************************************
// serial word framing
// ****************************************
`define ADDR_LAST_BIT 4'h7
`define WORD_LAST_BIT 4'hf
`define SYNC_RESET 4'h4

`endif

// file: rtl/pin_sync.v
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // asynchronous pins
  input wire [WIDTH-1:0] din,
  // synchronised levels
  output wire [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // first stage feeds only the second stage
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;

endmodule // pin_sync

// file: tb/link_controller_model.sv
// model of the controller that drives the serial configuration link
`timescale 1ns/1ps
module link_controller_model (
  // link pins toward the port
  output logic serial_select_n,
  output logic shift_clk,
  output logic serial_in_line,
  output logic reset_pin,
  // shared readback pin
  input wire logic overrange_or_readback_out
);
  // ****
  // link timing and capture
  // ****
  int hi_ns = 32;
  int lo_ns = 32;
  logic [7:0] rd_byte;

  initial begin
    serial_select_n = 1'b1;
    shift_clk = 1'b0;
    serial_in_line = 1'b0;
    reset_pin = 1'b0;
  end

  // data is set a whole phase before the fall; phases may be unequal
  task send_bit(input logic b);
    shift_clk = 1'b1;
    serial_in_line = b;
    #(hi_ns);
    shift_clk = 1'b0;
    rd_byte = {rd_byte[6:0], overrange_or_readback_out};
    #(lo_ns);
  endtask

  // whole words, address then data, msb first; stub bits come from a fixed word
  task frame(input logic [15:0] w[$], input int extra);
    logic [15:0] stub;
    stub = 16'h2601;
    rd_byte = 8'h00;
    #1.3;
    serial_select_n = 1'b0;
    #(hi_ns);
    foreach (w[i]) begin
      for (int b = 15; b >= 0; b--) send_bit(w[i][b]);
    end
    for (int b = 15; b > 15 - extra; b--) send_bit(stub[b]);
    serial_select_n = 1'b1;
    // released line must not keep its last value
    serial_in_line = ~serial_in_line;
    #100;
  endtask

  // shift edges with select high, which the port must ignore
  task noise(input logic [15:0] w);
    for (int b = 15; b >= 0; b--) send_bit(w[b]);
    serial_in_line = ~serial_in_line;
  endtask

  // pulse well above the minimum and far below the maximum width
  task pulse_reset();
    reset_pin = 1'b1;
    #40;
    reset_pin = 1'b0;
    #120;
  endtask
endmodule  // link_controller_model

// file: tb/adc_serial_config_port_sva.sv
// assertions on the ports of the serial configuration port
`timescale 1ns/1ps
module adc_serial_config_port_sva (
  // clock and reset
  input wire clk,
  input wire nrst,
  // inputs
  input wire serial_select_n,
  input wire reset_pin,
  input wire overrange_flag,
  // outputs
  input wire overrange_or_readback_out,
  input wire readout_active,
  input wire [3:0] gain_code,
  input wire gain_bypass,
  input wire [2:0] test_pattern_sel,
  input wire [11:0] user_pattern,
  input wire [5:0] swing_level,
  input wire swing_override,
  input wire clock_driver_termination,
  input wire data_driver_termination,
  input wire latency_extend,
  input wire offset_corr_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ****
  // properties
  // ****
  chk_idle_holds: assert property ((serial_select_n && !reset_pin)[*8] |-> $stable({gain_code, user_pattern,
    swing_level, clock_driver_termination, data_driver_termination})) else $error("setting moved while idle");
  chk_gain_range: assert property (gain_code <= 4'hc) else $error("gain code above twelve");
  chk_bypass_zero: assert property (gain_bypass |-> gain_code == 4'h0) else $error("gain while bypassed");
  chk_lowlat_gain: assert property (!latency_extend |-> gain_bypass) else $error("gain in low latency");
  chk_pattern_gate: assert property (test_pattern_sel < 3'h6 && (latency_extend || test_pattern_sel == 3'h0))
    else $error("pattern code not allowed");
  chk_offset_gate: assert property (offset_corr_en |-> latency_extend) else $error("offset loop in low latency");
  chk_swing_gate: assert property (!swing_override |-> swing_level == 6'h00) else $error("swing not gated");
  chk_flag_follow: assert property ($past(nrst) && !readout_active && !$past(readout_active)
    |-> overrange_or_readback_out == $past(overrange_flag)) else $error("pin does not follow flag");
  chk_readout_idle: assert property ((readout_active && serial_select_n)[*6] |-> !overrange_or_readback_out)
    else $error("readback pin busy while idle");
  chk_hw_reset: assert property (reset_pin[*7] |-> !readout_active && gain_bypass && !swing_override
    && !latency_extend && user_pattern == 12'h000) else $error("reset pin left settings");
endmodule  // adc_serial_config_port_sva

bind adc_serial_config_port adc_serial_config_port_sva i_adc_serial_config_port_sva (.clk, .nrst,
  .serial_select_n, .reset_pin, .overrange_flag, .overrange_or_readback_out, .readout_active, .gain_code,
  .gain_bypass, .test_pattern_sel, .user_pattern, .swing_level, .swing_override, .clock_driver_termination,
  .data_driver_termination, .latency_extend, .offset_corr_en);

// file: tb/tb.sv
// self-checking bench for the serial configuration port
`timescale 1ns/1ps
module tb;
  // ****
  // clock, reset and wiring
  // ****
  logic clk, nrst, overrange_flag;
  wire serial_select_n, shift_clk, serial_in_line, reset_pin, overrange_or_readback_out, readout_active;
  wire gain_bypass, swing_override, clock_driver_termination, data_driver_termination, latency_extend;
  wire offset_corr_en, offset_freeze, performance_tune_b_field, standby, global_power_down;
  wire output_buffer_power_down, low_speed_mode;
  wire [3:0] gain_code, offset_time_const, offset_pedestal;
  wire [2:0] test_pattern_sel;
  wire [11:0] user_pattern;
  wire [5:0] swing_level;
  wire [7:0] interface_clock_edge_ctrl;
  wire [1:0] clock_fall_position, data_format, performance_tune_a_field;
  int errors = 0;
  int n_tests = 0;

  adc_serial_config_port i_adc_serial_config_port (.clk, .nrst, .serial_select_n, .shift_clk, .serial_in_line,
    .reset_pin, .overrange_flag, .overrange_or_readback_out, .readout_active, .gain_code, .gain_bypass,
    .test_pattern_sel, .user_pattern, .swing_level, .swing_override, .clock_driver_termination,
    .data_driver_termination, .interface_clock_edge_ctrl, .clock_fall_position, .latency_extend, .data_format,
    .offset_corr_en, .offset_freeze, .offset_time_const, .offset_pedestal, .performance_tune_a_field,
    .performance_tune_b_field, .standby, .global_power_down, .output_buffer_power_down, .low_speed_mode);

  link_controller_model i_link (.serial_select_n, .shift_clk, .serial_in_line, .reset_pin,
    .overrange_or_readback_out);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****
  // helpers
  // ****
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [63:0] snap();
    snap = 64'({readout_active, user_pattern, interface_clock_edge_ctrl, performance_tune_a_field,
      performance_tune_b_field, low_speed_mode, offset_pedestal, offset_freeze, offset_time_const,
      clock_driver_termination, data_driver_termination, swing_level, swing_override, clock_fall_position,
      latency_extend, standby, data_format, offset_corr_en, gain_code, gain_bypass, test_pattern_sel,
      global_power_down, output_buffer_power_down});
  endfunction

  task set_flag(input logic v);
    @(negedge clk);
    overrange_flag = v;
    repeat (3) @(negedge clk);
  endtask

  task summarize();
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****
  // scenarios
  // ****
  task t_defaults();
    chk(snap(), 64'h20);
    set_flag(1'b1);
    chk(64'(overrange_or_readback_out), 64'h1);
    set_flag(1'b0);
  endtask

  // many words in one select period, a stub that must be dropped, edges while idle
  task t_bank_write();
    logic [63:0] e;
    i_link.noise(16'h2603);
    repeat (8) @(negedge clk);
    chk(64'({clock_driver_termination, data_driver_termination}), 64'h0);
    i_link.frame('{16'h3fa5, 16'h40c0, 16'h415a, 16'h0303, 16'h4a01, 16'hdf30, 16'hbf90, 16'hcfa8,
      16'h2602, 16'h01f8, 16'h4353, 16'h42c8, 16'h3da0, 16'h25c5}, 15);
    e = 64'({1'b0, 12'ha5c, 8'h5a, 2'h3, 1'b1, 1'b1, 4'h9, 1'b1, 4'ha, 1'b1, 1'b0, 6'h3e, 1'b1,
      2'h3, 1'b1, 1'b0, 2'h2, 1'b1, 4'hc, 1'b0, 3'h5, 1'b1, 1'b1});
    chk(snap(), e);
  endtask

  task t_gain_modes();
    logic [15:0] w [3];
    logic [8:0] e [3];
    w = '{16'h25ce, 16'h25d4, 16'h4200};
    e = '{9'h011, 9'h189, 9'h010};
    for (int i = 0; i < 3; i++) begin
      i_link.frame('{w[i]}, 0);
      chk(64'({gain_code, gain_bypass, test_pattern_sel, offset_corr_en}), 64'(e[i]));
    end
  endtask

  task t_readback();
    logic [15:0] w [3];
    w = '{16'h3f00, 16'h0001, 16'h0200};
    set_flag(1'b1);
    i_link.frame('{16'h0001}, 0);
    chk(64'({readout_active, overrange_or_readback_out}), 64'h2);
    i_link.frame('{16'h2600, 16'h2600}, 0);
    chk(64'(i_link.rd_byte), 64'h02);
    for (int i = 0; i < 3; i++) begin
      i_link.frame('{w[i]}, 0);
      chk(64'(i_link.rd_byte), (i == 0) ? 64'ha5 : 64'h00);
    end
    i_link.frame('{16'h0000}, 0);
    chk(64'({readout_active, overrange_or_readback_out}), 64'h1);
    i_link.frame('{16'h2601}, 0);
    chk(64'({clock_driver_termination, data_driver_termination}), 64'h1);
    set_flag(1'b0);
  endtask

  // long high phase then long low phase
  task t_slow_clock();
    i_link.hi_ns = 200;
    i_link.lo_ns = 26;
    i_link.frame('{16'h3d40}, 0);
    chk(64'({data_format, offset_corr_en}), 64'h2);
    i_link.hi_ns = 26;
    i_link.lo_ns = 200;
    i_link.frame('{16'h3de0}, 0);
    chk(64'({data_format, offset_corr_en}), 64'h6);
    i_link.hi_ns = 32;
    i_link.lo_ns = 32;
  endtask

  task t_soft_reset();
    i_link.frame('{16'h0002}, 0);
    chk(snap(), 64'h20);
    i_link.frame('{16'h2603}, 0);
    chk(64'({clock_driver_termination, data_driver_termination}), 64'h3);
  endtask

  task t_hw_reset();
    i_link.frame('{16'h3fff, 16'h0001}, 0);
    i_link.pulse_reset();
    chk(snap(), 64'h20);
    set_flag(1'b1);
    chk(64'(overrange_or_readback_out), 64'h1);
  endtask

  // ****
  // main sequence and watchdog
  // ****
  initial begin
    nrst = 1'b0;
    overrange_flag = 1'b0;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_defaults();
    t_bank_write();
    t_gain_modes();
    t_readback();
    t_slow_clock();
    t_soft_reset();
    t_hw_reset();
    summarize();
  end

  // a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule  // tb
